// >>> src/pmcks_pkg.sv
// constants for the second pll and master clock selection block
package pmcks_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PMCKS_OFF_PLLB  = 8'h00; // second_pll_config
  localparam logic [7:0] PMCKS_OFF_MCK   = 8'h04; // master_clock_config
  localparam logic [7:0] PMCKS_OFF_PCK0  = 8'h08; // programmable_clock_config 0
  localparam logic [7:0] PMCKS_OFF_PCK1  = 8'h0c; // programmable_clock_config 1
  localparam logic [7:0] PMCKS_OFF_IER   = 8'h10; // event_interrupt_enable
  localparam logic [7:0] PMCKS_OFF_IDR   = 8'h14; // event_interrupt_disable
  localparam logic [7:0] PMCKS_OFF_SR    = 8'h18; // clock_status
  localparam logic [7:0] PMCKS_OFF_IMR   = 8'h1c; // interrupt mask readback
  localparam logic [7:0] PMCKS_OFF_EVT   = 8'h20; // sticky events, clear on read

  // ----------------------------------------------------------------
  // second_pll_config field positions
  // ----------------------------------------------------------------
  localparam int PMCKS_DIV_LSB   = 0;
  localparam int PMCKS_DIV_W     = 8;
  localparam int PMCKS_CNT_LSB   = 8;
  localparam int PMCKS_CNT_W     = 6;
  localparam int PMCKS_RANGE_LSB = 14;
  localparam int PMCKS_RANGE_W   = 2;
  localparam int PMCKS_MUL_LSB   = 16;
  localparam int PMCKS_MUL_W     = 11;
  localparam int PMCKS_USB_LSB   = 28;
  localparam int PMCKS_USB_W     = 2;

  // ----------------------------------------------------------------
  // master / programmable clock field positions
  // ----------------------------------------------------------------
  localparam int PMCKS_SEL_LSB   = 0;
  localparam int PMCKS_SEL_W     = 2;
  localparam int PMCKS_PSC_LSB   = 2;
  localparam int PMCKS_PSC_W     = 3;
  localparam int PMCKS_MCDIV_LSB = 8;
  localparam int PMCKS_MCDIV_W   = 2;

  // ----------------------------------------------------------------
  // status / event bit positions
  // ----------------------------------------------------------------
  localparam int PMCKS_SR_OSC    = 0;
  localparam int PMCKS_SR_LOCK1  = 1;
  localparam int PMCKS_SR_LOCK2  = 2;
  localparam int PMCKS_SR_MRDY   = 3;
  localparam int PMCKS_SR_SLOWSRC = 7;
  localparam int PMCKS_SR_PCK0   = 8;
  localparam int PMCKS_SR_PCK1   = 9;
  localparam logic [31:0] PMCKS_EVT_MASK = 32'h0000_030f; // bits that carry events

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] PMCKS_PLLB_RST = 32'h0000_0000;
  localparam logic [31:0] PMCKS_MCK_RST  = 32'h0000_0000;
  localparam logic [31:0] PMCKS_PCK_RST  = 32'h0000_0000;
  localparam logic [2:0]  PMCKS_PSC_RSVD  = 3'h7; // prescaler code with no output
  localparam logic [1:0]  PMCKS_DIV2_RSVD = 2'h3; // reserved two-bit divider code
  localparam logic [11:0] PMCKS_CREDIT_MAX = 12'hfff;

endpackage : pmcks_pkg

// >>> src/pmcks_prescaler.sv
// source selector plus power-of-two prescaler on clock-enable ticks
`timescale 1ns/100ps
`default_nettype none
module pmcks_prescaler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] src_tick,
  input  wire logic [1:0] src_sel,
  input  wire logic [2:0] clock_prescaler_code,
  input  wire logic       restart,
  output logic            tick_out
);
  import pmcks_pkg::*;

  logic [5:0] count_r;
  logic [5:0] limit;
  logic       src_hit;

  // terminal count is 2**code - 1, code 111 never fires
  assign limit   = 6'((7'd1 << clock_prescaler_code) - 7'd1);
  assign src_hit = src_tick[src_sel] && (clock_prescaler_code != PMCKS_PSC_RSVD);

  // count selected ticks, emit one tick per full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r  <= 6'h00;
      tick_out <= 1'b0;
    end else if (restart) begin
      count_r  <= 6'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (src_hit) begin
        if (count_r == limit) begin
          count_r  <= 6'h00;
          tick_out <= 1'b1;
        end else begin
          count_r <= count_r + 6'h01;
        end
      end
    end
  end

endmodule : pmcks_prescaler
`default_nettype wire

// >>> src/pmcks_top.sv
// second pll, master clock and programmable clock control with apb registers
//
// Overview of operation
// - input divider: 0 stops, 1 passes, else divides
// - lock flag after programmed slow clock count
// - multiplier zero switches second pll off
// - output rate is input times multiplier plus one
// - usb divider by 1, 2, 4; 11 reserved
// - source select: slow, main, pll a, pll b
// - processor prescaler divides 1 to 64
// - master divider by 1, 2, 4; 11 reserved
// - each programmable clock selects its own source
// - each programmable clock has own prescaler
// - enable register sets mask bits on ones
// - disable register clears mask bits on ones
// - status bit 0 shows oscillator stable
// - status bits 1 and 2 show pll locks
// - first pll lock flag follows lock level
// - status bit 3 shows master clock ready
// - status bit 7 shows slow clock source
// - status bits 8, 9 show programmable ready
`timescale 1ns/100ps
`default_nettype none
module pmcks_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_clk_tick,
  input  wire logic        main_clk_tick,
  input  wire logic        first_pll_clk_tick,
  input  wire logic        main_osc_stable,
  input  wire logic        first_pll_locked,
  input  wire logic        slow_clock_source,
  output logic             second_pll_clk_tick,
  output logic             usb_clk_tick,
  output logic             proc_clk_tick,
  output logic             master_clk_tick,
  output logic [1:0]       prog_clk_tick,
  output logic [1:0]       second_pll_freq_range,
  output logic             irq
);
  import pmcks_pkg::*;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup_ph;
  logic        access_ph;
  logic        addr_hit;
  logic        wr_en;
  logic        rd_en;
  logic        wr_pllb;
  logic        wr_mck;
  logic [1:0]  wr_pck;
  logic        wr_ier;
  logic        wr_idr;
  logic        rd_evt;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;

  // address decode over the nine mapped words
  always_comb begin
    case (paddr)
      PMCKS_OFF_PLLB, PMCKS_OFF_MCK, PMCKS_OFF_PCK0, PMCKS_OFF_PCK1,
      PMCKS_OFF_IER, PMCKS_OFF_IDR, PMCKS_OFF_SR, PMCKS_OFF_IMR,
      PMCKS_OFF_EVT: addr_hit = 1'b1;
      default:       addr_hit = 1'b0;
    endcase
  end

  // zero wait state slave, error on unmapped word
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !addr_hit;
  assign wr_en     = access_ph && pwrite && addr_hit;
  assign rd_en     = access_ph && !pwrite && addr_hit;
  assign wr_pllb   = wr_en && (paddr == PMCKS_OFF_PLLB);
  assign wr_mck    = wr_en && (paddr == PMCKS_OFF_MCK);
  assign wr_pck[0] = wr_en && (paddr == PMCKS_OFF_PCK0);
  assign wr_pck[1] = wr_en && (paddr == PMCKS_OFF_PCK1);
  assign wr_ier    = wr_en && (paddr == PMCKS_OFF_IER);
  assign wr_idr    = wr_en && (paddr == PMCKS_OFF_IDR);
  assign rd_evt    = rd_en && (paddr == PMCKS_OFF_EVT);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] pllb_cfg_r;
  logic [31:0] mck_cfg_r;
  logic [31:0] pck_cfg_r [2];
  logic [9:0]  imask_r;

  // second pll configuration, reserved bits kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pllb_cfg_r <= PMCKS_PLLB_RST;
    end else if (wr_pllb) begin
      pllb_cfg_r <= pwdata & 32'h37ff_ffff;
    end
  end

  // master clock configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mck_cfg_r <= PMCKS_MCK_RST;
    end else if (wr_mck) begin
      mck_cfg_r <= pwdata & 32'h0000_031f;
    end
  end

  // programmable clock configurations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pck_cfg_r[0] <= PMCKS_PCK_RST;
      pck_cfg_r[1] <= PMCKS_PCK_RST;
    end else begin
      if (wr_pck[0]) begin
        pck_cfg_r[0] <= pwdata & 32'h0000_001f;
      end
      if (wr_pck[1]) begin
        pck_cfg_r[1] <= pwdata & 32'h0000_001f;
      end
    end
  end

  // interrupt mask: ones set on enable, ones clear on disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_r <= 10'h000;
    end else if (wr_ier) begin
      imask_r <= imask_r | pwdata[9:0] & PMCKS_EVT_MASK[9:0];
    end else if (wr_idr) begin
      imask_r <= imask_r & ~pwdata[9:0];
    end
  end

  // ----------------------------------------------------------------
  // second pll fields
  // ----------------------------------------------------------------
  logic [7:0]  div_val;
  logic [10:0] mul_val;
  logic [1:0]  usb_val;
  logic        pllb_on;

  assign div_val = pllb_cfg_r[PMCKS_DIV_LSB +: PMCKS_DIV_W];
  assign mul_val = pllb_cfg_r[PMCKS_MUL_LSB +: PMCKS_MUL_W];
  assign usb_val = pllb_cfg_r[PMCKS_USB_LSB +: PMCKS_USB_W];
  assign pllb_on = (mul_val != 11'h000);

  // frequency range field goes to the analog pll through one pclk register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_pll_freq_range <= 2'h0;
    end else begin
      second_pll_freq_range <= pllb_cfg_r[PMCKS_RANGE_LSB +: PMCKS_RANGE_W];
    end
  end

  // ----------------------------------------------------------------
  // second pll input divider on main clock ticks
  // ----------------------------------------------------------------
  logic [7:0] div_cnt_r;
  logic       ref_tick_r;

  // 0 gives no ticks, 1 passes, n divides by n
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r  <= 8'h00;
      ref_tick_r <= 1'b0;
    end else if (wr_pllb) begin
      div_cnt_r  <= 8'h00;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= 1'b0;
      if (main_clk_tick && div_val == 8'h01) begin
        ref_tick_r <= 1'b1;
      end else if (main_clk_tick && div_val > 8'h01) begin
        if (div_cnt_r >= div_val - 8'h01) begin
          div_cnt_r  <= 8'h00;
          ref_tick_r <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // second pll multiplier as a tick credit pool
  // ----------------------------------------------------------------
  logic [11:0] credit_r;
  logic [12:0] credit_sum;

  // each reference tick adds multiplier plus one output ticks
  always_comb begin
    credit_sum = {1'b0, credit_r};
    if (ref_tick_r) begin
      credit_sum = credit_sum + {2'b00, mul_val} + 13'h0001;
    end
    if (credit_sum != 13'h0000) begin
      credit_sum = credit_sum - 13'h0001;
    end
  end

  // one output tick per cycle while credit remains, saturating pool
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_r            <= 12'h000;
      second_pll_clk_tick <= 1'b0;
    end else if (!pllb_on || wr_pllb) begin
      credit_r            <= 12'h000;
      second_pll_clk_tick <= 1'b0;
    end else begin
      second_pll_clk_tick <= (credit_r != 12'h000) || ref_tick_r;
      if (credit_sum[12]) begin
        credit_r <= PMCKS_CREDIT_MAX;
      end else begin
        credit_r <= credit_sum[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // second pll lock counter on slow clock ticks
  // ----------------------------------------------------------------
  logic [5:0] lock_cnt_r;
  logic       lock_busy_r;
  logic       second_pll_locked_r;

  // a write restarts the count, lock after that many slow ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r  <= 6'h00;
      lock_busy_r <= 1'b0;
      second_pll_locked_r     <= 1'b0;
    end else if (wr_pllb) begin
      lock_cnt_r  <= pwdata[PMCKS_CNT_LSB +: PMCKS_CNT_W];
      lock_busy_r <= 1'b1;
      second_pll_locked_r     <= 1'b0;
    end else if (!pllb_on) begin
      lock_busy_r <= 1'b0;
      second_pll_locked_r     <= 1'b0;
    end else if (lock_busy_r) begin
      if (lock_cnt_r == 6'h00) begin
        lock_busy_r <= 1'b0;
        second_pll_locked_r     <= 1'b1;
      end else if (slow_clk_tick) begin
        lock_cnt_r <= lock_cnt_r - 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // usb divider on second pll ticks
  // ----------------------------------------------------------------
  logic [1:0] usb_cnt_r;

  // code 00 passes, 01 halves, 10 quarters, 11 gives nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_cnt_r    <= 2'h0;
      usb_clk_tick <= 1'b0;
    end else if (wr_pllb) begin
      usb_cnt_r    <= 2'h0;
      usb_clk_tick <= 1'b0;
    end else begin
      usb_clk_tick <= 1'b0;
      if (second_pll_clk_tick && usb_val != PMCKS_DIV2_RSVD) begin
        if (usb_cnt_r >= 2'((3'd1 << usb_val) - 3'd1)) begin
          usb_cnt_r    <= 2'h0;
          usb_clk_tick <= 1'b1;
        end else begin
          usb_cnt_r <= usb_cnt_r + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // processor, master and programmable clock dividers
  // ----------------------------------------------------------------
  logic [3:0] src_ticks;
  logic [3:0] ps_src   [4];
  logic [1:0] ps_sel   [4];
  logic [2:0] ps_clock_prescaler  [4];
  logic [3:0] ps_start;
  logic [3:0] ps_tick;
  logic [1:0] mcdiv_val;

  // source order slow, main, first pll, second pll
  assign src_ticks = {second_pll_clk_tick, first_pll_clk_tick, main_clk_tick,
                      slow_clk_tick};
  assign mcdiv_val = mck_cfg_r[PMCKS_MCDIV_LSB +: PMCKS_MCDIV_W];

  // stage 0 processor, stage 1 master, stages 2 and 3 programmable
  assign ps_src[0]  = src_ticks;
  assign ps_sel[0]  = mck_cfg_r[PMCKS_SEL_LSB +: PMCKS_SEL_W];
  assign ps_clock_prescaler[0] = mck_cfg_r[PMCKS_PSC_LSB +: PMCKS_PSC_W];
  assign ps_src[1]  = {3'h0, ps_tick[0]};
  assign ps_sel[1]  = 2'h0;
  assign ps_clock_prescaler[1] = (mcdiv_val == PMCKS_DIV2_RSVD) ? PMCKS_PSC_RSVD
                                                     : {1'b0, mcdiv_val};
  assign ps_start[0] = wr_mck;
  assign ps_start[1] = wr_mck;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pck_cfg
      assign ps_src[gi+2]   = src_ticks;
      assign ps_sel[gi+2]   = pck_cfg_r[gi][PMCKS_SEL_LSB +: PMCKS_SEL_W];
      assign ps_clock_prescaler[gi+2]  = pck_cfg_r[gi][PMCKS_PSC_LSB +: PMCKS_PSC_W];
      assign ps_start[gi+2] = wr_pck[gi];
    end
    for (gi = 0; gi < 4; gi++) begin : g_stage
      pmcks_prescaler u_ps (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_tick  (ps_src[gi]),
        .src_sel   (ps_sel[gi]),
        .clock_prescaler_code (ps_clock_prescaler[gi]),
        .restart   (ps_start[gi]),
        .tick_out  (ps_tick[gi])
      );
    end
  endgenerate

  assign proc_clk_tick   = ps_tick[0];
  assign master_clk_tick = ps_tick[1];
  assign prog_clk_tick   = ps_tick[3:2];

  // ----------------------------------------------------------------
  // ready flags: low after a config write, high at first new tick
  // ----------------------------------------------------------------
  logic       mck_rdy_r;
  logic [1:0] pck_rdy_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mck_rdy_r <= 1'b0;
    end else if (wr_mck) begin
      mck_rdy_r <= 1'b0;
    end else if (master_clk_tick) begin
      mck_rdy_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pck_rdy_r <= 2'h0;
    end else begin
      pck_rdy_r <= (pck_rdy_r & ~wr_pck) | (prog_clk_tick & ~wr_pck);
    end
  end

  // ----------------------------------------------------------------
  // status word and sticky events
  // ----------------------------------------------------------------
  logic [31:0] status;
  logic [9:0]  status_q_r;
  logic [9:0]  evt_r;
  logic [9:0]  evt_set;

  // live levels, neighbouring logic drives them on pclk
  always_comb begin
    status = 32'h0000_0000;
    status[PMCKS_SR_OSC]     = main_osc_stable;
    status[PMCKS_SR_LOCK1]   = first_pll_locked;
    status[PMCKS_SR_LOCK2]   = second_pll_locked_r;
    status[PMCKS_SR_MRDY]    = mck_rdy_r;
    status[PMCKS_SR_SLOWSRC] = slow_clock_source;
    status[PMCKS_SR_PCK0]    = pck_rdy_r[0];
    status[PMCKS_SR_PCK1]    = pck_rdy_r[1];
  end

  // rising edge of an event flag raises its sticky bit
  assign evt_set = status[9:0] & ~status_q_r & PMCKS_EVT_MASK[9:0];

  // read clears, a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q_r <= 10'h000;
      evt_r      <= 10'h000;
    end else begin
      status_q_r <= status[9:0];
      evt_r      <= (evt_r & {10{~rd_evt}}) | evt_set;
    end
  end

  // level interrupt from enabled sticky events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((((evt_r & {10{~rd_evt}}) | evt_set)) & imask_r);
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      case (paddr)
        PMCKS_OFF_PLLB: prdata <= pllb_cfg_r;
        PMCKS_OFF_MCK:  prdata <= mck_cfg_r;
        PMCKS_OFF_PCK0: prdata <= pck_cfg_r[0];
        PMCKS_OFF_PCK1: prdata <= pck_cfg_r[1];
        PMCKS_OFF_SR:   prdata <= status;
        PMCKS_OFF_IMR:  prdata <= {22'h000000, imask_r};
        PMCKS_OFF_EVT:  prdata <= {22'h000000, evt_r | evt_set};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : pmcks_top
`default_nettype wire

// >>> verif/pmcks_top_monitor.sv
// port checker for the second pll and master clock block
`timescale 1ns/100ps
`default_nettype none
module pmcks_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        second_pll_clk_tick,
  input wire logic        usb_clk_tick,
  input wire logic        proc_clk_tick,
  input wire logic        master_clk_tick,
  input wire logic [1:0]  second_pll_freq_range,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // request sequences
  // ----------------------------------------------------------------
  sequence s_wr(logic [7:0] a); psel && penable && pwrite && paddr == a; endsequence
  sequence s_wr_pll; s_wr(8'h00); endsequence
  sequence s_wr_mck; s_wr(8'h04); endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err; psel && penable && paddr > 8'h20 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped access");
  property p_range;
    s_wr_pll |-> ##2 second_pll_freq_range == $past(pwdata[15:14], 2);
  endproperty
  a_range: assert property (p_range) else $error("freq range not updated");
  property p_div0; s_wr_pll ##0 pwdata[7:0] == 0 |-> ##3 !second_pll_clk_tick [*8]; endproperty
  a_div0: assert property (p_div0) else $error("pll ticks with divider zero");
  property p_mul0; s_wr_pll ##0 pwdata[26:16] == 0 |-> ##3 !second_pll_clk_tick [*8]; endproperty
  a_mul0: assert property (p_mul0) else $error("pll ticks with multiplier zero");
  property p_usb3; s_wr_pll ##0 pwdata[29:28] == 3 |-> ##3 !usb_clk_tick [*8]; endproperty
  a_usb3: assert property (p_usb3) else $error("usb ticks on reserved code");
  property p_usb_src; usb_clk_tick |-> $past(second_pll_clk_tick); endproperty
  a_usb_src: assert property (p_usb_src) else $error("usb tick without pll tick");
  property p_psc7; s_wr_mck ##0 pwdata[4:2] == 7 |-> ##2 !proc_clk_tick [*8]; endproperty
  a_psc7: assert property (p_psc7) else $error("proc ticks on reserved code");
  property p_mcdiv3; s_wr_mck ##0 pwdata[9:8] == 3 |-> ##3 !master_clk_tick [*8]; endproperty
  a_mcdiv3: assert property (p_mcdiv3) else $error("master ticks on reserved code");
  property p_mst_src; master_clk_tick |-> $past(proc_clk_tick); endproperty
  a_mst_src: assert property (p_mst_src) else $error("master tick without proc tick");
  property p_idr; s_wr(8'h14) ##0 pwdata[9:0] == 10'h30f |-> ##2 !irq [*2]; endproperty
  a_idr: assert property (p_idr) else $error("irq high after disable all");
endmodule : pmcks_top_monitor
`default_nettype wire

// >>> verif/tb_pmcks_top.sv
// self-checking bench for the second pll and master clock block
`timescale 1ns/100ps
`default_nettype none
module tb_pmcks_top;
  import pmcks_pkg::*;
  localparam int DV[5] = '{0, 1, 4, 8, 16};
  localparam int MU[5] = '{3, 0, 2, 7, 15};
  localparam int UB[5] = '{0, 0, 1, 2, 3};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        slw = 0, mn = 0, pa = 0, osc = 0, lka = 0, ssrc = 0;
  logic        pready, pslverr, ptk, utk, prc, mst, irq;
  logic [1:0]  pck, rng;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  int          n_fail = 0, n_checks = 0, cnt[6] = '{default: 0}, got[6];
  wire  [5:0]  tk = {pck, mst, prc, utk, ptk};

  pmcks_top pmcks_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_clk_tick(slw), .main_clk_tick(mn), .first_pll_clk_tick(pa),
    .main_osc_stable(osc), .first_pll_locked(lka), .slow_clock_source(ssrc),
    .second_pll_clk_tick(ptk), .usb_clk_tick(utk), .proc_clk_tick(prc),
    .master_clk_tick(mst), .prog_clk_tick(pck), .second_pll_freq_range(rng), .irq(irq));

  always #12.5 pclk = ~pclk;

  // output tick counters
  always @(posedge pclk) begin
    for (int i = 0; i < 6; i++) cnt[i] <= cnt[i] + tk[i];
  end

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // one apb transfer, waits on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // drive one source for len cycles, then count output ticks
  task automatic burst(input int sel, input int len);
    int b[6];
    b = cnt;
    for (int i = 0; i < len; i++) begin
      {slw, mn, pa} <= {sel == 0, sel == 1, sel == 2};
      @(posedge pclk);
    end
    {slw, mn, pa} <= 3'h0;
    repeat (24) @(posedge pclk);
    for (int i = 0; i < 6; i++) got[i] = cnt[i] - b[i];
  endtask : burst

  // read result watcher
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && eq.size() > 0)
      chk("read", {pslverr, prdata & mq.pop_front()}, eq.pop_front());
  end

  initial begin
    #250000;
    n_fail++;
    conclude();
  end

  initial begin
    logic [2:0]  v;
    logic [31:0] d;
    int          e, s, m, x;
    void'($urandom(73615));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 0, '1);
    rd(8'h04, 0, '1);
    rd(8'h10, 0, '1);
    rd(8'h24, 33'h1_0000_0000, '1);
    for (int i = 0; i < 8; i++) begin
      v = 3'($urandom());
      {osc, lka, ssrc} <= v;
      repeat (2) @(posedge pclk);
      rd(8'h18, {24'h0, v[0], 5'h0, v[1], v[2]}, 32'h83);
    end
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      apb(1'b1, 8'(4 * i), d);
      rd(8'(4 * i), d & ((i == 0) ? 32'h37ff_ffff : (i == 1) ? 32'h31f : 32'h1f), '1);
    end
    apb(1'b1, 8'h00, 32'h0);
    $display("test registers done");
    for (int p = 0; p < 8; p++) begin
      s = p % 3;
      m = p % 4;
      apb(1'b1, 8'h04, (m << 8) | (p << 2) | s);
      apb(1'b1, 8'h08, (p << 2) | s);
      apb(1'b1, 8'h0c, (p << 2) | s);
      burst(s, 128);
      e = (p == 7) ? 0 : 128 >> p;
      x = (m == 3) ? 0 : e >> m;
      chk("proc", got[2], e);
      chk("master", got[3], x);
      chk("prog0", got[4], e);
      chk("prog1", got[5], e);
      rd(8'h18, {22'h0, {2{e != 0}}, 4'h0, x != 0, 3'h0}, 32'h308);
    end
    $display("test dividers done");
    apb(1'b1, 8'h04, 32'h3);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, (UB[i] << 28) | (MU[i] << 16) | DV[i]);
      burst(1, 128);
      e = (DV[i] == 0 || MU[i] == 0) ? 0 : (128 / DV[i]) * (MU[i] + 1);
      chk("pll", got[0], e);
      chk("usb", got[1], (UB[i] == 3) ? 0 : e >> UB[i]);
      chk("proc", got[2], e);
    end
    apb(1'b1, 8'h00, (1 << 16) | (5 << 8) | 1);
    burst(0, 4);
    rd(8'h18, 0, 32'h4);
    burst(0, 1);
    rd(8'h18, 32'h4, 32'h4);
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge pclk);
    rd(8'h18, 0, 32'h4);
    $display("test pll done");
    apb(1'b1, 8'h14, 32'h30f);
    rd(8'h20, 0, 0);
    osc <= 1'b0;
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    rd(8'h1c, 32'h1, 32'h30f);
    osc <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1);
    rd(8'h20, 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 0);
    apb(1'b1, 8'h14, 32'h1);
    rd(8'h1c, 0, 32'h30f);
    osc <= 1'b0;
    @(posedge pclk);
    osc <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("irq", irq, 0);
    $display("test interrupts done");
    conclude();
  end
endmodule : tb_pmcks_top

bind pmcks_top pmcks_top_monitor pmcks_top_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .second_pll_clk_tick(second_pll_clk_tick),
  .usb_clk_tick(usb_clk_tick), .proc_clk_tick(proc_clk_tick),
  .master_clk_tick(master_clk_tick), .second_pll_freq_range(second_pll_freq_range),
  .irq(irq));
`default_nettype wire
